// ---- hrc_pkg.sv ----
// constants shared by the high-speed reset/chirp sequencer
// assumes a single 20 MHz core clock; times are turned into cycles here
package hrc_pkg;
	// clock period
	localparam int CLK_PERIOD_NS = 50;
	// least continuous J time before a device chirp counts (2.5 us)
	localparam int CHIRP_J_MIN_NS = 2500;
	localparam int CHIRP_J_CYC = (CHIRP_J_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// device chirp must end by this time after reset start (7 ms)
	localparam int CHIRP_DEADLINE_US = 7000;
	localparam int CHIRP_DEADLINE_CYC = (CHIRP_DEADLINE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// least reset drive time (50 ms)
	localparam int RESET_DRIVE_US = 50000;
	localparam int RESET_DRIVE_CYC = (RESET_DRIVE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// host chirp bit length, middle of the 40..60 us window
	localparam int CHIRP_BIT_US = 50;
	localparam int CHIRP_BIT_CYC = (CHIRP_BIT_US * 1000) / CLK_PERIOD_NS;
	// stop processing time, about 6 cycles at 60 MHz (100 ns)
	localparam int CANCEL_NS = 100;
	localparam int CANCEL_CYC = (CANCEL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// timer width, large enough for the reset drive count
	localparam int TIMER_W = 21;

	// host negotiation control register fields
	localparam int CTRL_CANCEL_BIT = 7;
	localparam int CTRL_CMD_LSB = 0;
	localparam int CTRL_CMD_W = 4;
	localparam logic [3:0] CMD_NONE = 4'h0;
	localparam logic [3:0] CMD_BUS_RESET = 4'h1;
	localparam logic [3:0] CMD_GO_DISABLED = 4'h3;

	// host state monitor encodings
	localparam logic [1:0] HOST_IDLE = 2'h0;
	localparam logic [1:0] HOST_RESET = 2'h1;
	localparam logic [1:0] HOST_DISABLED = 2'h2;

	// transceiver encodings
	localparam logic [1:0] TRANSCEIVER_OP_MODE_NORMAL = 2'h0;
	localparam logic [1:0] TRANSCEIVER_OP_MODE_NONDRIVE = 2'h1;
	localparam logic [1:0] LINE_SE0 = 2'h0;
	localparam logic [1:0] LINE_J = 2'h1;

	// reset values
	localparam logic [1:0] HOST_STATE_RST = HOST_IDLE;
	localparam logic [1:0] TRANSCEIVER_OP_MODE_RST = TRANSCEIVER_OP_MODE_NONDRIVE;

	typedef enum logic [2:0] {
		SEQ_IDLE,
		SEQ_DETECT,
		SEQ_WAIT_CHIRP_END,
		SEQ_HOST_CHIRP,
		SEQ_RESET_HOLD,
		SEQ_CANCEL
	} hrc_seq_e;
endpackage

// ---- hrc_line_sync.sv ----
// three-stage synchroniser for the transceiver line state
// assumes lineIn changes freely relative to core_clk
module hrc_line_sync #(
	parameter int WIDTH = 2
) (
	// clock and control
	input wire logic core_clk,
	input wire logic srst,
	input wire logic clkEn,
	// line
	input wire logic [WIDTH-1:0] lineIn,
	output logic [WIDTH-1:0] lineOut
);
	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] sync2_r;
	logic [WIDTH-1:0] sync3_r;

	// shift chain; the first stage feeds only the second
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			meta_r <= '0;
			sync2_r <= '0;
			sync3_r <= '0;
		end
		else if (clkEn)
		begin
			meta_r <= lineIn;
			sync2_r <= meta_r;
			sync3_r <= sync2_r;
		end
	end

	// take a new value only once stages two and three agree, to reject glitches
	always_ff @(posedge core_clk)
	begin
		if (srst)
			lineOut <= '0;
		else if (clkEn && (sync2_r == sync3_r))
			lineOut <= sync3_r;
	end
endmodule

// ---- hrc_reset_seq.sv ----
// host bus-reset sequencer: high-speed detection handshake and chirp error path
// assumes firmware drives the control strobes from core_clk, line state arrives async
// Function
// - with finish-disable 0, a chirp error never leads to host chirping before reset ends.
// - bus-reset command sets host state monitor to reset immediately, then runs automatically.
// - at start, transceiver and termination select high speed, op mode normal.
// - enable chirp detection; chirp recognised after J held at least 2.5 us.
// - device chirp not ended 7 ms after start sets chirp error flag.
// - chirp detection is disabled in the same cycle the error flag sets.
// - mode 0 ends reset at least 50 ms after error, then sets reset complete.
// - with finish-disable 1, after error wait chirp end then chirp as host.
// - cancel stops the sequence and self-clears after the stop time.
// - in host-chirp mode, line falling to SE0 sets high speed and chirp ok.
// - host chirp starts with K then alternates K and J until ended.
module hrc_reset_seq
	import hrc_pkg::*;
#(
	parameter int DEADLINE_CYC = CHIRP_DEADLINE_CYC,
	parameter int DRIVE_CYC = RESET_DRIVE_CYC
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic srst,
	input wire logic clkEn,
	// host negotiation control write port
	input wire logic ctrlWrite,
	input wire logic [7:0] ctrlData,
	input wire logic chirpFinishDisable,
	// flag clears, one-cycle pulses
	input wire logic clrChirpError,
	input wire logic clrChirpOk,
	input wire logic clrResetComplete,
	// transceiver line state, asynchronous
	input wire logic [1:0] lineStateA,
	// control state shown to firmware
	output logic [3:0] hostStateCommand,
	output logic autoCancel,
	output logic [1:0] hostStateMonitor,
	output logic chirpErrorFlag,
	output logic chirpOkFlag,
	output logic resetCompleteFlag,
	// transceiver controls
	output logic transceiverSelect,
	output logic terminationSelect,
	output logic [1:0] transceiverOpMode,
	output logic portSpeedHs,
	output logic chirpDetectEn,
	output logic hostChirpDrive,
	output logic hostChirpK
);
	hrc_seq_e seq_r;
	logic [1:0] lineSync;
	logic [TIMER_W-1:0] timer_r;
	logic [11:0] jCount_r;
	logic [11:0] bitCount_r;
	logic chirpSeen_r;
	logic startReset;
	logic startCancel;
	logic lineJ;
	logic lineSe0;
	logic deadlineHit;
	logic driveDone;
	logic setError;
	logic setOk;
	logic setComplete;

	hrc_line_sync #(
		.WIDTH(2)
	) uLineSync (
		.core_clk(core_clk),
		.srst(srst),
		.clkEn(clkEn),
		.lineIn(lineStateA),
		.lineOut(lineSync)
	);

	// decode of the control write; cancel outranks any command in the same write
	assign startCancel = ctrlWrite && ctrlData[CTRL_CANCEL_BIT];
	assign startReset = ctrlWrite && !ctrlData[CTRL_CANCEL_BIT]
		&& (ctrlData[CTRL_CMD_LSB +: CTRL_CMD_W] == CMD_BUS_RESET);
	assign lineJ = (lineSync == LINE_J);
	assign lineSe0 = (lineSync == LINE_SE0);
	assign deadlineHit = (timer_r >= TIMER_W'(DEADLINE_CYC - 1));
	assign driveDone = (timer_r >= TIMER_W'(DRIVE_CYC - 1));

	// event strobes feeding the sticky flags
	assign setError = (seq_r == SEQ_DETECT) && deadlineHit && !(chirpSeen_r && lineSe0);
	assign setOk = (seq_r == SEQ_WAIT_CHIRP_END) && lineSe0;
	assign setComplete = (seq_r == SEQ_RESET_HOLD || seq_r == SEQ_HOST_CHIRP) && driveDone;

	// sequencer; the device chirp start within 6.0 ms is not checked, only the 7 ms end
	always_ff @(posedge core_clk)
	begin
		if (srst)
			seq_r <= SEQ_IDLE;
		else if (clkEn)
		begin
			if (startCancel)
				seq_r <= SEQ_CANCEL;
			else if (startReset)
				seq_r <= SEQ_DETECT;
			else
			begin
				unique case (seq_r)
					SEQ_IDLE: seq_r <= SEQ_IDLE;
					SEQ_DETECT:
					begin
						if (setError)
							seq_r <= chirpFinishDisable ? SEQ_WAIT_CHIRP_END : SEQ_RESET_HOLD;
						else if (chirpSeen_r && lineSe0)
							seq_r <= SEQ_WAIT_CHIRP_END;
					end
					SEQ_WAIT_CHIRP_END:
					begin
						if (lineSe0)
							seq_r <= SEQ_HOST_CHIRP;
					end
					SEQ_HOST_CHIRP:
					begin
						if (driveDone)
							seq_r <= SEQ_IDLE;
					end
					SEQ_RESET_HOLD:
					begin
						if (driveDone)
							seq_r <= SEQ_IDLE;
					end
					SEQ_CANCEL:
					begin
						if (timer_r >= TIMER_W'(CANCEL_CYC - 1))
							seq_r <= SEQ_IDLE;
					end
				endcase
			end
		end
	end

	// shared timer, restarted on reset start, cancel, chirp error and chirp ok
	always_ff @(posedge core_clk)
	begin
		if (srst)
			timer_r <= '0;
		else if (clkEn)
		begin
			if (startCancel || startReset || setError || setOk)
				timer_r <= '0;
			else if (seq_r != SEQ_IDLE && seq_r != SEQ_WAIT_CHIRP_END)
				timer_r <= timer_r + TIMER_W'(1);
		end
	end

	// device chirp qualifier: J must hold unbroken for the minimum time
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			jCount_r <= '0;
			chirpSeen_r <= 1'b0;
		end
		else if (clkEn)
		begin
			if (startReset || !chirpDetectEn || !lineJ)
				jCount_r <= '0;
			else if (jCount_r < 12'(CHIRP_J_CYC))
				jCount_r <= jCount_r + 12'h001;
			if (startReset || startCancel)
				chirpSeen_r <= 1'b0;
			else if (chirpDetectEn && lineJ && jCount_r >= 12'(CHIRP_J_CYC - 1))
				chirpSeen_r <= 1'b1;
		end
	end

	// detection enable follows the start and drops with the error
	always_ff @(posedge core_clk)
	begin
		if (srst)
			chirpDetectEn <= 1'b0;
		else if (clkEn)
		begin
			if (startReset)
				chirpDetectEn <= 1'b1;
			else if (startCancel || setError || (seq_r == SEQ_DETECT && chirpSeen_r && lineSe0))
				chirpDetectEn <= 1'b0;
		end
	end

	// command field, cancel bit and host state monitor
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			hostStateCommand <= CMD_NONE;
			autoCancel <= 1'b0;
			hostStateMonitor <= HOST_STATE_RST;
		end
		else if (clkEn)
		begin
			if (ctrlWrite)
				hostStateCommand <= ctrlData[CTRL_CMD_LSB +: CTRL_CMD_W];
			if (startCancel)
				autoCancel <= 1'b1;
			else if (seq_r == SEQ_CANCEL && timer_r >= TIMER_W'(CANCEL_CYC - 1))
				autoCancel <= 1'b0;
			if (startReset)
				hostStateMonitor <= HOST_RESET;
			else if (ctrlWrite && !ctrlData[CTRL_CANCEL_BIT] && seq_r == SEQ_IDLE && !autoCancel
				&& ctrlData[CTRL_CMD_LSB +: CTRL_CMD_W] == CMD_GO_DISABLED)
				hostStateMonitor <= HOST_DISABLED; // ignored while a sequence or cancel runs
		end
	end

	// transceiver setup at reset start
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			transceiverSelect <= 1'b0;
			terminationSelect <= 1'b0;
			transceiverOpMode <= TRANSCEIVER_OP_MODE_RST;
			portSpeedHs <= 1'b0;
		end
		else if (clkEn)
		begin
			if (startReset)
			begin
				transceiverSelect <= 1'b1;
				terminationSelect <= 1'b1;
				transceiverOpMode <= TRANSCEIVER_OP_MODE_NORMAL;
				portSpeedHs <= 1'b0;
			end
			else if (setOk)
				portSpeedHs <= 1'b1;
		end
	end

	// host chirp generator: K first, then K/J per bit time
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			hostChirpDrive <= 1'b0;
			hostChirpK <= 1'b0;
			bitCount_r <= '0;
		end
		else if (clkEn)
		begin
			if (startCancel || startReset || seq_r != SEQ_HOST_CHIRP || driveDone)
			begin
				// only this state drives, so the error path of mode 0 stays silent
				// a cancel or restart in the same cycle as the chirp start must not leave a one-cycle drive
				hostChirpDrive <= setOk && !startCancel && !startReset;
				hostChirpK <= setOk && !startCancel && !startReset;
				bitCount_r <= '0;
			end
			else if (bitCount_r >= 12'(CHIRP_BIT_CYC - 1))
			begin
				hostChirpK <= !hostChirpK;
				bitCount_r <= '0;
			end
			else
				bitCount_r <= bitCount_r + 12'h001;
		end
	end

	// sticky flags; a set in the same cycle as a clear wins
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			chirpErrorFlag <= 1'b0;
			chirpOkFlag <= 1'b0;
			resetCompleteFlag <= 1'b0;
		end
		else if (clkEn)
		begin
			if (setError)
				chirpErrorFlag <= 1'b1;
			else if (clrChirpError)
				chirpErrorFlag <= 1'b0;
			if (setOk)
				chirpOkFlag <= 1'b1;
			else if (clrChirpOk)
				chirpOkFlag <= 1'b0;
			if (setComplete && !startCancel)
				resetCompleteFlag <= 1'b1;
			else if (clrResetComplete)
				resetCompleteFlag <= 1'b0;
		end
	end
endmodule

// ---- hrc_reset_seq_sva.sv ----
// checker for the host bus-reset sequencer, ports of hrc_reset_seq only
// assumes the bind below and counts in core_clk cycles
module hrc_reset_seq_chk
	import hrc_pkg::*;
#(
	parameter int DEADLINE_CYC = CHIRP_DEADLINE_CYC,
	parameter int DRIVE_CYC = RESET_DRIVE_CYC
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic srst,
	input wire logic clkEn,
	// control
	input wire logic ctrlWrite,
	input wire logic [7:0] ctrlData,
	input wire logic chirpFinishDisable,
	input wire logic clrChirpError,
	input wire logic clrChirpOk,
	input wire logic clrResetComplete,
	// status and transceiver
	input wire logic [3:0] hostStateCommand,
	input wire logic autoCancel,
	input wire logic [1:0] hostStateMonitor,
	input wire logic chirpErrorFlag,
	input wire logic chirpOkFlag,
	input wire logic resetCompleteFlag,
	input wire logic transceiverSelect,
	input wire logic terminationSelect,
	input wire logic [1:0] transceiverOpMode,
	input wire logic portSpeedHs,
	input wire logic chirpDetectEn,
	input wire logic hostChirpDrive,
	input wire logic hostChirpK
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	logic errQ_r;
	int cnt_r;
	// cycles since reset start, restarted at the error so one counter serves both spans
	always_ff @(posedge core_clk)
	begin
		errQ_r <= chirpErrorFlag;
		if (srst || (ctrlWrite && !ctrlData[7] && ctrlData[3:0] == CMD_BUS_RESET) || (chirpErrorFlag && !errQ_r))
			cnt_r <= 0;
		else if (clkEn)
			cnt_r <= cnt_r + 1;
	end
	reset_start_a: assert property (ctrlWrite && clkEn && ctrlData == 8'h01 |=> hostStateMonitor == HOST_RESET
		&& transceiverSelect && terminationSelect && transceiverOpMode == TRANSCEIVER_OP_MODE_NORMAL && chirpDetectEn)
		else $error("bus reset start outputs wrong");
	err_deadline_a: assert property ($rose(chirpErrorFlag) |-> cnt_r inside {[DEADLINE_CYC-2:DEADLINE_CYC+2]})
		else $error("chirp error at wrong time");
	detect_off_a: assert property ($rose(chirpErrorFlag) |-> !chirpDetectEn && $past(chirpDetectEn))
		else $error("detect not disabled with error");
	no_host_chirp_a: assert property (!chirpFinishDisable && chirpErrorFlag |-> !hostChirpDrive)
		else $error("host chirp after error in mode 0");
	drive_time_a: assert property ($rose(resetCompleteFlag) && chirpErrorFlag |-> cnt_r >= DRIVE_CYC-3)
		else $error("reset ended too early");
	chirp_start_a: assert property ($rose(hostChirpDrive) |-> chirpOkFlag && portSpeedHs
		##0 hostChirpK[*8] ##[1:1000] !hostChirpK)
		else $error("host chirp not K first or no toggle");
	err_sticky_a: assert property (chirpErrorFlag && !clrChirpError |=> chirpErrorFlag)
		else $error("error flag dropped");
	done_sticky_a: assert property (resetCompleteFlag && !clrResetComplete |=> resetCompleteFlag)
		else $error("complete flag dropped");
	ok_sticky_a: assert property (chirpOkFlag && !clrChirpOk |=> chirpOkFlag)
		else $error("ok flag dropped");
	cancel_clear_a: assert property (ctrlWrite && clkEn && ctrlData[7] |=> autoCancel
		&& hostStateCommand == CMD_NONE ##1 autoCancel ##1 !autoCancel)
		else $error("cancel bit timing wrong");
endmodule
bind hrc_reset_seq hrc_reset_seq_chk #(.DEADLINE_CYC(DEADLINE_CYC), .DRIVE_CYC(DRIVE_CYC)) u_chk (
	.core_clk(core_clk),
	.srst(srst),
	.clkEn(clkEn),
	.ctrlWrite(ctrlWrite),
	.ctrlData(ctrlData),
	.chirpFinishDisable(chirpFinishDisable),
	.clrChirpError(clrChirpError),
	.clrChirpOk(clrChirpOk),
	.clrResetComplete(clrResetComplete),
	.hostStateCommand(hostStateCommand),
	.autoCancel(autoCancel),
	.hostStateMonitor(hostStateMonitor),
	.chirpErrorFlag(chirpErrorFlag),
	.chirpOkFlag(chirpOkFlag),
	.resetCompleteFlag(resetCompleteFlag),
	.transceiverSelect(transceiverSelect),
	.terminationSelect(terminationSelect),
	.transceiverOpMode(transceiverOpMode),
	.portSpeedHs(portSpeedHs),
	.chirpDetectEn(chirpDetectEn),
	.hostChirpDrive(hostChirpDrive),
	.hostChirpK(hostChirpK)
);

// ---- hrc_dev_model.sv ----
// attached device model: chirps J on the line after each start pulse
// assumes core_clk from the bench; the line rests at SE0 (pulled down)
module hrc_dev_model
	import hrc_pkg::*;
(
	// clock
	input wire logic core_clk,
	// start pulse and chirp length in cycles
	input wire logic go,
	input wire logic [15:0] jLen,
	// line toward host
	output logic [1:0] lineStateA
);
	timeunit 1ns;
	timeprecision 1ns;
	// one process owns the line; chirp begins a few cycles after reset start, well inside the start limit
	initial
	begin
		lineStateA = LINE_SE0;
		forever
		begin
			@(posedge go);
			repeat (5) @(posedge core_clk);
			#2 lineStateA = LINE_J;
			repeat (jLen) @(posedge core_clk);
			#2 lineStateA = LINE_SE0;
		end
	end
endmodule

// ---- tb_top.sv ----
// self-checking bench for hrc_reset_seq with shortened counts
// assumes hrc_pkg, the device model and the bound checker
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import hrc_pkg::*;
	localparam int DL = 200;
	localparam int DR = 3000;
	typedef struct {logic mode; logic [15:0] jl; logic [7:0] exp;} hrc_row_s;
	logic core_clk = 0, srst = 1, clkEn = 1, ctrlWrite = 0, chirpFinishDisable = 0, go = 0, seen;
	logic clrChirpError = 0, clrChirpOk = 0, clrResetComplete = 0;
	logic [7:0] ctrlData = 8'h00;
	logic [15:0] jLen = 16'h0000;
	logic [1:0] lineStateA, hostStateMonitor, transceiverOpMode;
	logic [3:0] hostStateCommand;
	logic autoCancel, chirpErrorFlag, chirpOkFlag, resetCompleteFlag, transceiverSelect, terminationSelect;
	logic portSpeedHs, chirpDetectEn, hostChirpDrive, hostChirpK;
	int err_total = 0, tests_run = 0;
	// rows: mode, J length, expected {high speed, error, ok, complete, host chirp seen}
	hrc_row_s rows [4] = '{'{1'b0, 16'h0190, 8'h0A}, '{1'b1, 16'h0190, 8'h1F}, '{1'b0, 16'h0014, 8'h0A},
		'{1'b0, 16'h003C, 8'h17}};
	always #25 core_clk = ~core_clk;
	hrc_reset_seq #(.DEADLINE_CYC(DL), .DRIVE_CYC(DR)) u_dut (
		.core_clk(core_clk),
		.srst(srst),
		.clkEn(clkEn),
		.ctrlWrite(ctrlWrite),
		.ctrlData(ctrlData),
		.chirpFinishDisable(chirpFinishDisable),
		.clrChirpError(clrChirpError),
		.clrChirpOk(clrChirpOk),
		.clrResetComplete(clrResetComplete),
		.lineStateA(lineStateA),
		.hostStateCommand(hostStateCommand),
		.autoCancel(autoCancel),
		.hostStateMonitor(hostStateMonitor),
		.chirpErrorFlag(chirpErrorFlag),
		.chirpOkFlag(chirpOkFlag),
		.resetCompleteFlag(resetCompleteFlag),
		.transceiverSelect(transceiverSelect),
		.terminationSelect(terminationSelect),
		.transceiverOpMode(transceiverOpMode),
		.portSpeedHs(portSpeedHs),
		.chirpDetectEn(chirpDetectEn),
		.hostChirpDrive(hostChirpDrive),
		.hostChirpK(hostChirpK)
	);
	hrc_dev_model u_dev (
		.core_clk(core_clk),
		.go(go),
		.jLen(jLen),
		.lineStateA(lineStateA)
	);
	task automatic step(input int n);
		repeat (n) @(posedge core_clk);
		#2;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one-cycle write strobe, inputs move 2 ns after the edge
	task automatic wr(input logic [7:0] d);
		ctrlWrite = 1;
		ctrlData = d;
		step(1);
		ctrlWrite = 0;
	endtask
	task automatic wrap_up;
		if (err_total == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// watchdog sized well above the expected run of about 16000 cycles
	initial
	begin
		#(60000 * 50);
		err_total++;
		wrap_up;
	end
	initial
	begin
		step(12);
		srst = 0;
		chk({hostStateMonitor, transceiverOpMode, autoCancel, chirpErrorFlag, chirpOkFlag, resetCompleteFlag},
			{HOST_STATE_RST, TRANSCEIVER_OP_MODE_RST, 4'h0});
		foreach (rows[i])
		begin
			srst = 1;
			step(2);
			srst = 0;
			chirpFinishDisable = rows[i].mode;
			jLen = rows[i].jl;
			wr(8'h01);
			go = 1;
			chk({1'b0, hostStateMonitor, transceiverSelect, terminationSelect, transceiverOpMode, chirpDetectEn},
				{1'b0, HOST_RESET, 2'b11, TRANSCEIVER_OP_MODE_NORMAL, 1'b1});
			seen = 0;
			for (int c = 0; c < 5000 && resetCompleteFlag !== 1'b1; c++)
			begin
				step(1);
				seen = seen | hostChirpDrive;
			end
			go = 0;
			chk({portSpeedHs, chirpErrorFlag, chirpOkFlag, resetCompleteFlag, seen}, rows[i].exp);
			step(5);
			chk({portSpeedHs, chirpErrorFlag, chirpOkFlag, resetCompleteFlag, seen}, rows[i].exp);
			{clrChirpError, clrChirpOk, clrResetComplete} = 3'b111;
			step(1);
			{clrChirpError, clrChirpOk, clrResetComplete} = 3'b000;
			step(1);
			chk({chirpErrorFlag, chirpOkFlag, resetCompleteFlag}, 8'h00);
			wr(8'h03);
			chk(hostStateMonitor, HOST_DISABLED);
		end
		// disable refused while busy, a cancel lost while frozen, then cancel and a late disable
		step(1);
		wr(8'h01);
		step(1);
		wr(8'h03);
		chk({hostStateMonitor, hostStateCommand}, {2'b00, HOST_RESET, CMD_GO_DISABLED});
		step(1);
		clkEn = 0;
		wr(8'h80);
		step(2);
		chk({autoCancel, hostStateCommand}, {4'h0, CMD_GO_DISABLED});
		clkEn = 1;
		wr(8'h80);
		chk({autoCancel, hostStateCommand}, {4'h1, CMD_NONE});
		step(1);
		chk(autoCancel, 8'h01);
		step(1);
		chk(autoCancel, 8'h00);
		step(DL + DR);
		chk({resetCompleteFlag, hostChirpDrive}, 8'h00);
		wr(8'h03);
		chk(hostStateMonitor, HOST_DISABLED);
		wrap_up;
	end
endmodule
